// ---- hw/cllc_pkg.sv ----
// Package: constants and types for the capacity limit lock control block
// Notes on behaviour
// - Command F9h with feature 02h is decoded as a lock request.
// - Command F9h with feature 03h is decoded as an unlock request.
// - F9h right after read-native-max is a max-address set, features ignored.
// - An accepted lock request puts the device in the locked state.
// - Locked state rejects every sub-command except unlock and freeze-lock.
// - Locked holds until power cycle or accepted unlock or freeze-lock.
// - Unlock takes exactly one data sector; its password is compared.
// - Password mismatch aborts the command and decrements the attempt counter.
// - Attempt counter starts at 5, minus one per mismatch.
// - Counter at zero rejects all unlocks until hard reset or power off.
// - Matching password enters unlocked state; features 01h-04h accepted, other features aborted.
// - Stored password is volatile; lost on power cycle.
// - Locked or frozen state answers disallowed commands with abort.
// - Freeze-lock enters frozen state; all later sub-commands rejected.
package cllc_pkg;

  // APB byte offsets
  localparam logic [7:0] CLLC_OFS_CMD     = 8'h00;
  localparam logic [7:0] CLLC_OFS_FEAT    = 8'h04;
  localparam logic [7:0] CLLC_OFS_DATA    = 8'h08;
  localparam logic [7:0] CLLC_OFS_ERR     = 8'h0C;
  localparam logic [7:0] CLLC_OFS_STAT    = 8'h10;
  localparam logic [7:0] CLLC_OFS_STATE   = 8'h14;
  localparam logic [7:0] CLLC_OFS_PWSET   = 8'h18;
  localparam logic [7:0] CLLC_OFS_IRQ_ST  = 8'h1C;
  localparam logic [7:0] CLLC_OFS_IRQ_MSK = 8'h20;

  // Command and feature codes
  localparam logic [7:0] CLLC_CMD_SETMAX  = 8'hF9;
  localparam logic [7:0] CLLC_CMD_RDNAT   = 8'hF8;
  localparam logic [7:0] CLLC_FEAT_SETPW  = 8'h01;
  localparam logic [7:0] CLLC_FEAT_LOCK   = 8'h02;
  localparam logic [7:0] CLLC_FEAT_UNLOCK = 8'h03;
  localparam logic [7:0] CLLC_FEAT_FREEZE = 8'h04;

  // Error and status bit positions
  localparam int CLLC_ERR_ABORT_BIT = 2;
  localparam int CLLC_ST_BSY_BIT    = 7;
  localparam int CLLC_ST_RDY_BIT    = 6;
  localparam int CLLC_ST_DRQ_BIT    = 3;
  localparam int CLLC_ST_ERR_BIT    = 0;

  // State register fields
  localparam int CLLC_STATE_LSB = 0;
  localparam int CLLC_CNT_LSB   = 4;
  localparam int CLLC_RDNAT_BIT = 8;

  // Password set register fields
  localparam int CLLC_PW_IDX_LSB = 16;

  // Interrupt status bits
  localparam int CLLC_IRQ_DONE_BIT  = 0;
  localparam int CLLC_IRQ_ABORT_BIT = 1;
  localparam int CLLC_IRQ_EXH_BIT   = 2;
  localparam int CLLC_IRQ_W         = 3;

  // Reset values and counts
  localparam logic [2:0]  CLLC_ATTEMPTS_RST = 3'h5;
  localparam logic [7:0]  CLLC_STAT_RST     = 8'h40;
  localparam logic [7:0]  CLLC_ERR_RST      = 8'h00;
  localparam int          CLLC_SECTOR_WORDS = 256;
  localparam int          CLLC_PW_FIRST     = 1;
  localparam int          CLLC_PW_WORDS     = 16;

  typedef enum logic [1:0] {
    CLLC_UNLOCKED = 2'b00,
    CLLC_LOCKED   = 2'b01,
    CLLC_FROZEN   = 2'b10
  } cllc_lock_t;

  typedef enum logic [1:0] {
    CLLC_IDLE  = 2'b00,
    CLLC_EXEC  = 2'b01,
    CLLC_XFER  = 2'b10,
    CLLC_CHECK = 2'b11
  } cllc_fsm_t;

endpackage : cllc_pkg

// ---- hw/cllc_pw_cmp.sv ----
// Password store and one-sector password compare
`timescale 1ns/1ps
module cllc_pw_cmp
  import cllc_pkg::*;
#(
  parameter int SECTOR_WORDS = CLLC_SECTOR_WORDS,
  parameter int PW_WORDS     = CLLC_PW_WORDS
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        pw_we_in,
  input  wire logic [3:0]  pw_idx_in,
  input  wire logic [15:0] pw_data_in,
  input  wire logic        start_in,
  input  wire logic        word_vld_in,
  input  wire logic [15:0] word_in,
  output logic             done_out,
  output logic             match_out
);

  logic [15:0] pw_mem_q [PW_WORDS];
  logic [8:0]  wcnt_q;
  logic        busy_q;
  logic        mism_q;
  logic        done_q;
  logic        match_q;

  wire         in_pw   = (int'(wcnt_q) >= CLLC_PW_FIRST) &&
                         (int'(wcnt_q) < CLLC_PW_FIRST + PW_WORDS);
  wire  [3:0]  pw_sel  = 4'(wcnt_q - 9'(CLLC_PW_FIRST));
  wire         bad     = in_pw && (word_in != pw_mem_q[pw_sel]);
  wire         last    = int'(wcnt_q) == SECTOR_WORDS - 1;
  wire         take    = busy_q && word_vld_in;

  // Volatile store, cleared by reset like a power cycle
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < PW_WORDS; i++) begin
        pw_mem_q[i] <= 16'h0000;
      end
    end else if (pw_we_in) begin
      pw_mem_q[pw_idx_in] <= pw_data_in;
    end
  end

  // Exactly one sector is taken, then compare result
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wcnt_q  <= 9'h000;
      busy_q  <= 1'b0;
      mism_q  <= 1'b0;
      done_q  <= 1'b0;
      match_q <= 1'b0;
    end else begin
      done_q <= take && last;
      if (start_in) begin
        wcnt_q <= 9'h000;
        busy_q <= 1'b1;
        mism_q <= 1'b0;
      end else if (take) begin
        wcnt_q <= wcnt_q + 9'h001;
        mism_q <= mism_q | bad;
        if (last) begin
          busy_q  <= 1'b0;
          match_q <= !(mism_q | bad);
        end
      end
    end
  end

  assign done_out  = done_q;
  assign match_out = match_q;

endmodule : cllc_pw_cmp

// ---- hw/cllc_top.sv ----
// Capacity limit lock control: command FSM with APB register access
`timescale 1ns/1ps
module cllc_top
  import cllc_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic [31:0]      prdata_out,
  output logic             irq_out
);

  // APB decode; one wait state so read data comes from a flop
  logic        ack_q;
  logic [31:0] prdata_q;
  logic        slverr_q;

  wire access   = psel_in && penable_in;
  wire first    = access && !ack_q;
  wire fin      = access && ack_q;
  wire wr_fin   = fin && pwrite_in;
  wire rd_fin   = fin && !pwrite_in;

  wire hit_cmd  = paddr_in == CLLC_OFS_CMD;
  wire hit_feat = paddr_in == CLLC_OFS_FEAT;
  wire hit_data = paddr_in == CLLC_OFS_DATA;
  wire hit_err  = paddr_in == CLLC_OFS_ERR;
  wire hit_stat = paddr_in == CLLC_OFS_STAT;
  wire hit_st   = paddr_in == CLLC_OFS_STATE;
  wire hit_pw   = paddr_in == CLLC_OFS_PWSET;
  wire hit_ist  = paddr_in == CLLC_OFS_IRQ_ST;
  wire hit_imsk = paddr_in == CLLC_OFS_IRQ_MSK;
  wire mapped   = hit_cmd | hit_feat | hit_data | hit_err | hit_stat |
                  hit_st | hit_pw | hit_ist | hit_imsk;

  // Command engine state
  cllc_fsm_t   fsm_q;
  cllc_fsm_t   fsm_d;
  cllc_lock_t  lock_q;
  cllc_lock_t  lock_d;
  logic [7:0]  cmd_q;
  logic [7:0]  feat_q;
  logic [2:0]  cnt_q;
  logic [2:0]  cnt_d;
  logic        rdnat_q;
  logic        rdnat_d;
  logic        setmax_q;
  logic        bsy_q;
  logic        drq_q;
  logic        errf_q;
  logic        abort_q;
  logic        bsy_d;
  logic        drq_d;
  logic        errf_d;
  logic        abort_d;
  logic        cmp_start;
  logic        ev_done;
  logic        ev_abort;
  logic        ev_exh;
  logic [CLLC_IRQ_W-1:0] irq_st_q;
  logic [CLLC_IRQ_W-1:0] irq_msk_q;

  wire cmp_done;
  wire cmp_match;

  // New command only when not busy and not mid-transfer
  wire cmd_go   = wr_fin && hit_cmd && (fsm_q == CLLC_IDLE);
  wire word_vld = wr_fin && hit_data && (fsm_q == CLLC_XFER);

  // Sub-command decode
  wire is_setmax = cmd_q == CLLC_CMD_SETMAX;
  wire f_setpw   = feat_q == CLLC_FEAT_SETPW;
  wire f_lock    = feat_q == CLLC_FEAT_LOCK;
  wire f_unlock  = feat_q == CLLC_FEAT_UNLOCK;
  wire f_freeze  = feat_q == CLLC_FEAT_FREEZE;
  wire is_frozen = lock_q == CLLC_FROZEN;
  wire is_locked = lock_q == CLLC_LOCKED;
  wire cnt_zero  = cnt_q == 3'h0;

  // Accept or reject an F9h sub-command in the current lock state
  wire sub_ok = setmax_q  ? !is_locked && !is_frozen :
                is_frozen ? 1'b0 :
                is_locked ? (f_unlock || f_freeze) :
                (f_setpw || f_lock || f_unlock || f_freeze);
  wire unlock_ok = f_unlock && !setmax_q && !cnt_zero;

  always_comb begin
    fsm_d     = fsm_q;
    lock_d    = lock_q;
    cnt_d     = cnt_q;
    rdnat_d   = rdnat_q;
    bsy_d     = bsy_q;
    drq_d     = drq_q;
    errf_d    = errf_q;
    abort_d   = abort_q;
    cmp_start = 1'b0;
    ev_done   = 1'b0;
    ev_abort  = 1'b0;
    ev_exh    = 1'b0;
    case (fsm_q)
      CLLC_IDLE: begin
        if (cmd_go) begin
          fsm_d   = CLLC_EXEC;
          bsy_d   = 1'b1;
          errf_d  = 1'b0;
          abort_d = 1'b0;
        end
      end
      CLLC_EXEC: begin
        rdnat_d = cmd_q == CLLC_CMD_RDNAT;
        fsm_d   = CLLC_IDLE;
        bsy_d   = 1'b0;
        ev_done = 1'b1;
        if (is_setmax) begin
          if (!sub_ok || (f_unlock && !setmax_q && !unlock_ok)) begin
            errf_d   = 1'b1;
            abort_d  = 1'b1;
            ev_abort = 1'b1;
          end else if (setmax_q) begin
            lock_d = lock_q;
          end else if (f_lock) begin
            lock_d = CLLC_LOCKED;
          end else if (f_freeze) begin
            lock_d = CLLC_FROZEN;
          end else if (f_unlock) begin
            fsm_d     = CLLC_XFER;
            bsy_d     = 1'b0;
            drq_d     = 1'b1;
            cmp_start = 1'b1;
            ev_done   = 1'b0;
          end
        end
      end
      CLLC_XFER: begin
        if (word_vld) begin
          drq_d = 1'b1;
        end
        if (cmp_done) begin
          fsm_d = CLLC_CHECK;
          drq_d = 1'b0;
          bsy_d = 1'b1;
        end
      end
      CLLC_CHECK: begin
        fsm_d   = CLLC_IDLE;
        bsy_d   = 1'b0;
        ev_done = 1'b1;
        if (cmp_match) begin
          lock_d = CLLC_UNLOCKED;
        end else begin
          errf_d   = 1'b1;
          abort_d  = 1'b1;
          ev_abort = 1'b1;
          cnt_d    = cnt_q - 3'h1;
          ev_exh   = cnt_q == 3'h1;
        end
      end
      default: begin
        fsm_d = CLLC_IDLE;
        bsy_d = 1'b0;
        drq_d = 1'b0;
      end
    endcase
  end

  // Lock state only leaves locked via unlock, freeze or reset paths
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fsm_q   <= CLLC_IDLE;
      lock_q  <= CLLC_UNLOCKED;
      cnt_q   <= CLLC_ATTEMPTS_RST;
      rdnat_q <= 1'b0;
      bsy_q   <= CLLC_STAT_RST[CLLC_ST_BSY_BIT];
      drq_q   <= CLLC_STAT_RST[CLLC_ST_DRQ_BIT];
      errf_q  <= CLLC_STAT_RST[CLLC_ST_ERR_BIT];
      abort_q <= CLLC_ERR_RST[CLLC_ERR_ABORT_BIT];
    end else begin
      fsm_q   <= fsm_d;
      lock_q  <= lock_d;
      cnt_q   <= cnt_d;
      rdnat_q <= rdnat_d;
      bsy_q   <= bsy_d;
      drq_q   <= drq_d;
      errf_q  <= errf_d;
      abort_q <= abort_d;
    end
  end

  // Command, feature and prior-command capture
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_q    <= 8'h00;
      feat_q   <= 8'h00;
      setmax_q <= 1'b0;
    end else begin
      if (wr_fin && hit_feat && fsm_q == CLLC_IDLE) begin
        feat_q <= pwdata_in[7:0];
      end
      if (cmd_go) begin
        cmd_q    <= pwdata_in[7:0];
        setmax_q <= rdnat_q;
      end
    end
  end

  cllc_pw_cmp #(
    .SECTOR_WORDS (CLLC_SECTOR_WORDS),
    .PW_WORDS     (CLLC_PW_WORDS)
  ) u_pw_cmp (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n_in),
    .pw_we_in    (wr_fin && hit_pw),
    .pw_idx_in   (pwdata_in[CLLC_PW_IDX_LSB +: 4]),
    .pw_data_in  (pwdata_in[15:0]),
    .start_in    (cmp_start),
    .word_vld_in (word_vld),
    .word_in     (pwdata_in[15:0]),
    .done_out    (cmp_done),
    .match_out   (cmp_match)
  );

  // Register images
  wire [7:0] err_img  = 8'(abort_q) << CLLC_ERR_ABORT_BIT;
  wire [7:0] stat_img = (8'(bsy_q) << CLLC_ST_BSY_BIT) |
                        (8'(!bsy_q) << CLLC_ST_RDY_BIT) |
                        (8'(drq_q) << CLLC_ST_DRQ_BIT) |
                        (8'(errf_q) << CLLC_ST_ERR_BIT);
  wire [31:0] st_img  = (32'(lock_q) << CLLC_STATE_LSB) |
                        (32'(cnt_q) << CLLC_CNT_LSB) |
                        (32'(rdnat_q) << CLLC_RDNAT_BIT);
  wire [31:0] rd_mux  = hit_cmd  ? {24'h000000, cmd_q} :
                        hit_feat ? {24'h000000, feat_q} :
                        hit_err  ? {24'h000000, err_img} :
                        hit_stat ? {24'h000000, stat_img} :
                        hit_st   ? st_img :
                        hit_ist  ? 32'(irq_st_q) :
                        hit_imsk ? 32'(irq_msk_q) : 32'h00000000;

  // Events: set wins over the read clear
  wire [CLLC_IRQ_W-1:0] ev_vec = {ev_exh, ev_abort, ev_done};
  wire ist_clr = rd_fin && hit_ist;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_st_q  <= '0;
      irq_msk_q <= '0;
    end else begin
      // Clear only what the read returned, so no event is lost
      irq_st_q <= (ist_clr ? (irq_st_q & ~prdata_q[CLLC_IRQ_W-1:0]) :
                   irq_st_q) | ev_vec;
      if (wr_fin && hit_imsk) begin
        irq_msk_q <= pwdata_in[CLLC_IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_q    <= 1'b0;
      prdata_q <= 32'h00000000;
      slverr_q <= 1'b0;
    end else begin
      ack_q <= first;
      if (first) begin
        prdata_q <= pwrite_in ? 32'h00000000 : rd_mux;
        slverr_q <= !mapped;
      end
    end
  end

  assign pready_out  = fin;
  assign pslverr_out = fin && slverr_q;
  assign prdata_out  = prdata_q;
  assign irq_out     = |(irq_st_q & irq_msk_q);

endmodule : cllc_top

// ---- tb/cllc_monitor.sv ----
// Port checker for the lock control block
`timescale 1ns/1ps
module cllc_monitor
  import cllc_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [31:0] prdata_out,
  input wire logic        irq_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  logic [2:0] msk_q;
  wire        rd_ok = pready_out && !pwrite_in;
  wire        top_ok = paddr_in <= CLLC_OFS_IRQ_MSK;
  // Shadow of the mask, taken at the write's ready edge
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) msk_q <= 3'h0;
    else if (pready_out && pwrite_in && paddr_in == CLLC_OFS_IRQ_MSK)
      msk_q <= pwdata_in[2:0];
  end
  chk_ready_delay: assert property ($rose(penable_in) && psel_in |=> pready_out)
    else $error("pready not in second access cycle");
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready held too long");
  chk_ready_access: assert property (pready_out |-> psel_in && penable_in)
    else $error("pready outside access phase");
  chk_unmapped_err: assert property (pready_out && paddr_in[1:0] == 2'h0
    && !top_ok |-> pslverr_out) else $error("unmapped without slave error");
  chk_mapped_ok: assert property (pready_out && paddr_in[1:0] == 2'h0
    && top_ok |-> !pslverr_out) else $error("slave error on mapped word");
  chk_abort_only: assert property (rd_ok && paddr_in == CLLC_OFS_ERR
    |-> (prdata_out & ~32'h4) == 32'h0) else $error("error bits besides abort");
  chk_err_done: assert property (rd_ok && paddr_in == CLLC_OFS_STAT
    && prdata_out[0] |-> prdata_out[7:6] == 2'h1) else $error("busy with error");
  chk_count_range: assert property (rd_ok && paddr_in == CLLC_OFS_STATE
    |-> prdata_out[6:4] <= 3'h5 && prdata_out[1:0] != 2'h3)
    else $error("attempt count or lock field out of range");
  chk_irq_masked: assert property (msk_q == 3'h0 && $past(msk_q) == 3'h0
    |-> !irq_out) else $error("interrupt with all sources masked");
  chk_irq_quiet: assert property ($rose(rst_n_in) |-> !irq_out)
    else $error("interrupt right after reset");
  cover property (rd_ok && paddr_in == CLLC_OFS_STATE && prdata_out[1:0] == 2'h1);
  cover property (rd_ok && paddr_in == CLLC_OFS_STATE && prdata_out[1:0] == 2'h2);
  cover property ($rose(irq_out));
  cover property (pready_out && pslverr_out);
endmodule : cllc_monitor

bind cllc_top cllc_monitor mon_u (.clk_sys_in, .rst_n_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out,
  .pslverr_out, .prdata_out, .irq_out);

// ---- tb/cllc_host_model.sv ----
// Host model: APB master that issues task-file commands
`timescale 1ns/1ps
module cllc_host_model (
  input  wire logic        clk_sys_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  input  wire logic [31:0] prdata_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [7:0]       paddr_out,
  output logic [31:0]      pwdata_out
);
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h0;
    pwdata_out = 32'h0;
  end
  // Answer taken at the rising edge that samples pready high
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk_sys_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_sys_in);
    penable_out <= 1'b1;
    do @(posedge clk_sys_in); while (pready_in !== 1'b1);
    r = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // Released address and data lines never keep the stale value
    paddr_out <= ~a;
    pwdata_out <= ~d;
  endtask : xfer
endmodule : cllc_host_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the lock control block
`timescale 1ns/1ps
module tb_top;
  import cllc_pkg::*;
  logic        clk_sys_in, rst_n_in, psel_in, penable_in, pwrite_in, er;
  logic        pready_out, pslverr_out, irq_out;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  int          mismatches, comparisons;
  initial clk_sys_in = 1'b0;
  always #50 clk_sys_in = ~clk_sys_in;
  cllc_top dut_u (.clk_sys_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .pready_out, .pslverr_out, .prdata_out, .irq_out);
  cllc_host_model host_u (.clk_sys_in, .pready_in(pready_out),
    .pslverr_in(pslverr_out), .prdata_in(prdata_out), .psel_out(psel_in),
    .penable_out(penable_in), .pwrite_out(pwrite_in),
    .paddr_out(paddr_in), .pwdata_out(pwdata_in));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, rd, er);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    host_u.xfer(1'b0, a, 32'h0, rd, er);
    cmp(rd, exp);
  endtask : rdc
  task automatic state(input logic [1:0] lk, input logic [2:0] cnt);
    rdc(CLLC_OFS_STATE, {25'h0, cnt, 2'h0, lk});
  endtask : state
  task automatic irq_is(input logic exp);
    @(negedge clk_sys_in);
    cmp({31'h0, irq_out}, {31'h0, exp});
  endtask : irq_is
  // Bounded poll so a stuck busy flag cannot hang the run
  task automatic idle();
    int n;
    n = 0;
    do begin
      host_u.xfer(1'b0, CLLC_OFS_STAT, 32'h0, rd, er);
      n++;
    end while (rd[CLLC_ST_BSY_BIT] !== 1'b0 && n < 20);
  endtask : idle
  task automatic run(input logic [7:0] f, input logic [7:0] c);
    wr(CLLC_OFS_FEAT, {24'h0, f});
    wr(CLLC_OFS_CMD, {24'h0, c});
    idle();
  endtask : run
  function automatic logic [15:0] pw(input int i);
    return 16'h5A00 + 16'(i);
  endfunction : pw
  // One whole sector; x flips password bits
  task automatic unlock(input logic [15:0] x, input logic dq,
    input logic [7:0] st);
    run(CLLC_FEAT_UNLOCK, CLLC_CMD_SETMAX);
    cmp({31'h0, rd[CLLC_ST_DRQ_BIT]}, {31'h0, dq});
    if (rd[CLLC_ST_DRQ_BIT] === 1'b1) begin
      for (int k = 0; k < CLLC_SECTOR_WORDS; k++)
        wr(CLLC_OFS_DATA,
           {16'h0, (k >= 1 && k <= 16) ? pw(k - 1) ^ x : 16'h0});
      idle();
    end
    cmp(rd, {24'h0, st});
  endtask : unlock
  task automatic do_reset();
    rst_n_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
  endtask : do_reset

  task automatic t_reset();
    rdc(CLLC_OFS_STAT, 32'h40);
    rdc(CLLC_OFS_ERR, 32'h0);
    state(2'h0, 3'h5);
    rdc(8'h24, 32'h0);
    cmp({31'h0, er}, 32'h1);
    for (int i = 0; i < CLLC_PW_WORDS; i++)
      wr(CLLC_OFS_PWSET, {12'h0, 4'(i), pw(i)});
    run(8'h0, CLLC_CMD_RDNAT);
    run(CLLC_FEAT_LOCK, CLLC_CMD_SETMAX);
    host_u.xfer(1'b0, CLLC_OFS_STATE, 32'h0, rd, er);
    cmp(rd & 32'hFF, 32'h50);
    $display("test reset and read-native pairing done");
  endtask : t_reset
  task automatic t_lock();
    run(CLLC_FEAT_LOCK, CLLC_CMD_SETMAX);
    cmp(rd, 32'h40);
    state(2'h1, 3'h5);
    run(CLLC_FEAT_SETPW, CLLC_CMD_SETMAX);
    cmp(rd, 32'h41);
    rdc(CLLC_OFS_ERR, 32'h4);
    run(CLLC_FEAT_LOCK, CLLC_CMD_SETMAX);
    cmp(rd, 32'h41);
    state(2'h1, 3'h5);
    $display("test lock done");
  endtask : t_lock
  task automatic t_unlock();
    unlock(16'h0100, 1'b1, 8'h41);
    rdc(CLLC_OFS_ERR, 32'h4);
    state(2'h1, 3'h4);
    unlock(16'h0, 1'b1, 8'h40);
    state(2'h0, 3'h4);
    run(CLLC_FEAT_SETPW, CLLC_CMD_SETMAX);
    cmp(rd, 32'h40);
    run(8'h07, CLLC_CMD_SETMAX);
    cmp(rd, 32'h41);
    rdc(CLLC_OFS_ERR, 32'h4);
    run(CLLC_FEAT_LOCK, CLLC_CMD_SETMAX);
    cmp(rd, 32'h40);
    $display("test unlock done");
  endtask : t_unlock
  task automatic t_exhaust();
    wr(CLLC_OFS_IRQ_MSK, 32'h2);
    // Done and abort events of earlier tests are still pending
    rdc(CLLC_OFS_IRQ_ST, 32'h3);
    irq_is(1'b0);
    unlock(16'h0001, 1'b1, 8'h41);
    irq_is(1'b1);
    host_u.xfer(1'b0, CLLC_OFS_IRQ_ST, 32'h0, rd, er);
    cmp({31'h0, rd[1]}, 32'h1);
    irq_is(1'b0);
    for (int i = 0; i < 3; i++)
      unlock(16'h8000, 1'b1, 8'h41);
    wr(CLLC_OFS_IRQ_MSK, 32'h4);
    irq_is(1'b1);
    unlock(16'h0, 1'b0, 8'h41);
    state(2'h1, 3'h0);
    $display("test attempt exhaustion done");
  endtask : t_exhaust
  task automatic t_power();
    do_reset();
    state(2'h0, 3'h5);
    run(CLLC_FEAT_LOCK, CLLC_CMD_SETMAX);
    unlock(16'h0, 1'b1, 8'h41);
    run(CLLC_FEAT_FREEZE, CLLC_CMD_SETMAX);
    cmp(rd, 32'h40);
    state(2'h2, 3'h4);
    unlock(16'h0, 1'b0, 8'h41);
    run(CLLC_FEAT_LOCK, CLLC_CMD_SETMAX);
    cmp(rd, 32'h41);
    $display("test reset and freeze done");
  endtask : t_power

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // Seven sectors at about 1000 cycles each, with margin
  initial begin
    #4000000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    mismatches = 0;
    comparisons = 0;
    rst_n_in = 1'b0;
    do_reset();
    t_reset();
    t_lock();
    t_unlock();
    t_exhaust();
    t_power();
    tally_and_finish();
  end
endmodule : tb_top
